/* src/ief_pkg.sv */
// Constants and carrier types of the isochronous endpoint block.
// Assumes a 25 MHz link clock and a bus interval marker from the link.
//
// Summary of operation
// - Burst above one forces 1024-byte packets.
// - Burst size clamped to at most 16.
// - At most three or six bursts per interval.
// - Short packets carry no padding bytes.
// - Only the last burst packet may be short.
// - Service interval is 2^(bInterval-1) bus intervals.
// - Up to three or six bursts anywhere inside each service interval.
// - Empty IN poll answers with zero-length packet.
// - No acknowledge, retry or flow-control answer.
// - Sequence restarts at zero, wraps after 31.
// - Sink reports rate; source accepts host rate.
// - Base period 2^13 bus intervals for 1 Hz.
// - Count master clock edges, load and clear.
// - Divider exponent kept between one and K-1.
// - Source adds rate to kept fraction each interval.
// - Rate sent as unsigned 32.32 eight bytes.
// - Integer part holds 16-bit sample count.
// - Current rate reported on every poll.
// - Drift pulses nudge reported rate by one step.
package ief_pkg;
  localparam int          MEAS_EXP        = 13;
  localparam int          FRAC_SHIFT      = 32 - MEAS_EXP;
  localparam logic [10:0] MAX_PKT_BYTES   = 11'h400;
  localparam logic [4:0]  MAX_BURST       = 5'h10;
  localparam logic [4:0]  MAX_BINTERVAL   = 5'h10;
  localparam logic [2:0]  BURSTS_GEN1     = 3'h3;
  localparam logic [2:0]  BURSTS_GEN2     = 3'h6;
  localparam int          BUS_INTERVAL_NS = 125000;
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          BUS_INTERVAL_CYC = BUS_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int          FIFO_WIDTH      = 8;
  localparam int          FIFO_DEPTH      = 32;
  localparam logic [11:0] TIMER_RST       = 12'h000;
  localparam logic [4:0]  SEQ_RST         = 5'h00;
  localparam logic [63:0] RATE_RST        = 64'h0;

  typedef struct packed {
    logic [10:0] max_pkt;
    logic [4:0]  max_burst;
    logic [4:0]  binterval;
    logic        gen2;
    logic [3:0]  div_exp;
  } ief_cfg_type;

  typedef struct packed {
    logic [10:0] len;
    logic [4:0]  seq;
    logic        last;
  } ief_hdr_type;
endpackage : ief_pkg

/* src/ief_endpoint.sv */
// Isochronous IN endpoint with explicit rate feedback and adaptive source.
// Assumes poll and bus marker pulses arrive on clk_in; master clock is a pin.
`timescale 1ns/1ps

module ief_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     nrst_in,
  // Fill side
  input  wire logic                     wr_valid_in,
  output logic                          wr_ready_out,
  input  wire logic [WIDTH-1:0]         wr_data_in,
  // Drain side
  output logic                          rd_valid_out,
  input  wire logic                     rd_ready_in,
  output logic [WIDTH-1:0]              rd_data_out,
  output logic [$clog2(DEPTH):0]        count_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp;
  logic [AW:0]      rp;
  logic [AW:0]      next_wp;
  logic [AW:0]      next_rp;
  logic             do_wr;
  logic             do_rd;
  logic             next_ready;

  always_comb begin
    count_out    = wp - rp;
    rd_valid_out = (count_out != '0);
    rd_data_out  = mem[rp[AW-1:0]];
    do_wr        = wr_valid_in && wr_ready_out;
    do_rd        = rd_ready_in && rd_valid_out;
    next_wp      = do_wr ? wp + 1'b1 : wp;
    next_rp      = do_rd ? rp + 1'b1 : rp;
    next_ready   = ((next_wp - next_rp) != DEPTH[AW:0]);
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      wp <= '0;
      rp <= '0;
      wr_ready_out <= 1'b1;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      wr_ready_out <= next_ready;
    end
    if (do_wr) begin
      mem[wp[AW-1:0]] <= wr_data_in;
    end
  end
endmodule : ief_fifo

module ief_endpoint (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  // Configuration
  input  wire ief_pkg::ief_cfg_type cfg_in,
  // Link timing and polls
  input  wire logic              bus_tick_in,
  input  wire logic              poll_in,
  input  wire logic [4:0]        poll_npkt_in,
  input  wire logic              fb_poll_in,
  // Sample source into the buffer
  input  wire logic              src_valid_in,
  input  wire logic [7:0]        src_data_in,
  output logic                   src_ready_out,
  // Packet stream to the link
  output ief_pkg::ief_hdr_type   hdr_out,
  output logic                   hdr_valid_out,
  output logic [7:0]             data_out,
  output logic                   data_valid_out,
  output logic                   data_last_out,
  output logic                   poll_drop_out,
  // Rate feedback sink
  input  wire logic              mclk_pin_in,
  input  wire logic              drift_up_in,
  input  wire logic              drift_dn_in,
  output logic [63:0]            fb_report_out,
  output logic                   fb_report_valid_out,
  // Adaptive source
  input  wire logic [63:0]       host_rate_in,
  input  wire logic              host_rate_valid_in,
  output logic [15:0]            samples_out,
  output logic                   samples_valid_out
);
  typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_DATA} ief_tx_type;

  function automatic logic [4:0] ief_clamp(input logic [4:0] v, input logic [4:0] lo,
                                           input logic [4:0] hi);
    ief_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : ief_clamp

  // ----------------------------------------
  // Effective configuration
  // ----------------------------------------
  logic [4:0]  burst;
  logic [10:0] pkt;
  logic [4:0]  bint;
  logic [4:0]  pexp;
  logic [2:0]  burst_lim;
  always_comb begin
    burst     = ief_clamp(cfg_in.max_burst, 5'h01, ief_pkg::MAX_BURST);
    pkt       = (burst > 5'h01) ? ief_pkg::MAX_PKT_BYTES :
                ((cfg_in.max_pkt > ief_pkg::MAX_PKT_BYTES) ?
                 ief_pkg::MAX_PKT_BYTES : cfg_in.max_pkt);
    bint      = ief_clamp(cfg_in.binterval, 5'h01, ief_pkg::MAX_BINTERVAL);
    // Zero or K would defeat averaging or lost-value tolerance
    pexp      = ief_clamp({1'b0, cfg_in.div_exp}, 5'h01, 5'(ief_pkg::MEAS_EXP - 1));
    burst_lim = cfg_in.gen2 ? ief_pkg::BURSTS_GEN2 : ief_pkg::BURSTS_GEN1;
  end

  // ----------------------------------------
  // Timing: bus interval and service interval
  // ----------------------------------------
  logic [11:0] tmr;
  logic [11:0] next_tmr;
  logic [15:0] svc;
  logic [15:0] next_svc;
  logic        tick;
  logic        svc_start;
  always_comb begin
    tick      = bus_tick_in || (tmr == 12'(ief_pkg::BUS_INTERVAL_CYC - 1));
    next_tmr  = tick ? ief_pkg::TIMER_RST : tmr + 12'h001;
    svc_start = tick && (svc == (16'h0001 << (bint - 5'h01)) - 16'h0001);
    next_svc  = svc_start ? 16'h0000 : (tick ? svc + 16'h0001 : svc);
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tmr <= ief_pkg::TIMER_RST;
      svc <= 16'h0000;
    end else begin
      tmr <= next_tmr;
      svc <= next_svc;
    end
  end

  // ----------------------------------------
  // Feedback measurement
  // ----------------------------------------
  logic        m1;
  logic        m2;
  logic        m3;
  logic [12:0] mint;
  logic [12:0] next_mint;
  logic [31:0] mcnt;
  logic [31:0] next_mcnt;
  logic [31:0] adj;
  logic [1:0]  drift;
  logic [1:0]  next_drift;
  logic [63:0] rate;
  logic [63:0] next_rate;
  logic        pend;
  logic        edge_seen;
  always_comb begin
    edge_seen  = m2 && !m3;
    pend       = tick && (mint == 13'((14'h0001 << (5'(ief_pkg::MEAS_EXP) - pexp)) - 14'h0001));
    next_mint  = pend ? 13'h0000 : (tick ? mint + 13'h0001 : mint);
    // The end-cycle edge belongs to the closing period, so none is lost
    adj        = mcnt + {31'h0, edge_seen} + {31'h0, drift[0]} - {31'h0, drift[1]};
    next_mcnt  = pend ? 32'h0 : mcnt + {31'h0, edge_seen};
    next_drift = (pend ? 2'h0 : drift) | {drift_dn_in, drift_up_in};
    // Low fraction bits stay zero beyond K
    next_rate  = pend ? (64'(adj) << ief_pkg::FRAC_SHIFT) : rate;
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      m1    <= 1'b0;
      m2    <= 1'b0;
      m3    <= 1'b0;
      mint  <= 13'h0000;
      mcnt  <= 32'h0;
      drift <= 2'h0;
      rate  <= ief_pkg::RATE_RST;
      fb_report_out       <= ief_pkg::RATE_RST;
      fb_report_valid_out <= 1'b0;
    end else begin
      m1    <= mclk_pin_in;
      m2    <= m1;
      m3    <= m2;
      mint  <= next_mint;
      mcnt  <= next_mcnt;
      drift <= next_drift;
      rate  <= next_rate;
      fb_report_out       <= fb_poll_in ? rate : fb_report_out;
      fb_report_valid_out <= fb_poll_in;
    end
  end

  // ----------------------------------------
  // Adaptive source accumulator
  // ----------------------------------------
  logic [63:0] hrate;
  logic [31:0] frac;
  logic [63:0] sum;
  always_comb begin
    sum = {32'h0, frac} + hrate;
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      hrate <= ief_pkg::RATE_RST;
      frac  <= 32'h0;
      samples_out       <= 16'h0000;
      samples_valid_out <= 1'b0;
    end else begin
      hrate <= host_rate_valid_in ? host_rate_in : hrate;
      frac  <= tick ? sum[31:0] : frac;
      samples_out       <= tick ? sum[47:32] : samples_out;
      samples_valid_out <= tick;
    end
  end

  // ----------------------------------------
  // Packet transmit
  // ----------------------------------------
  ief_tx_type                st;
  ief_tx_type                next_st;
  logic [4:0]                left;
  logic [4:0]                next_left;
  logic [2:0]                bursts;
  logic [2:0]                next_bursts;
  logic [4:0]                seq;
  logic [4:0]                next_seq;
  logic [10:0]               bytes;
  logic [10:0]               next_bytes;
  logic [10:0]               len;
  ief_pkg::ief_hdr_type      next_hdr;
  logic                      rd_ready;
  logic                      rd_valid;
  logic [7:0]                rd_data;
  logic [$clog2(ief_pkg::FIFO_DEPTH):0] fcnt;
  logic                      drop;
  logic                      fresh;
  logic                      next_fresh;

  // Buffer only grows while the link drains, so a snapshot length is safe
  ief_fifo #(.WIDTH(ief_pkg::FIFO_WIDTH), .DEPTH(ief_pkg::FIFO_DEPTH)) u_fifo (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .wr_valid_in  (src_valid_in),
    .wr_ready_out (src_ready_out),
    .wr_data_in   (src_data_in),
    .rd_valid_out (rd_valid),
    .rd_ready_in  (rd_ready),
    .rd_data_out  (rd_data),
    .count_out    (fcnt)
  );

  always_comb begin
    next_st     = st;
    next_left   = left;
    next_bursts = svc_start ? 3'h0 : bursts;
    next_seq    = seq;
    next_fresh  = svc_start || fresh;
    next_bytes  = bytes;
    next_hdr    = hdr_out;
    rd_ready    = 1'b0;
    drop        = 1'b0;
    len = (11'(fcnt) >= pkt) ? pkt : 11'(fcnt);
    case (st)
      TX_IDLE: begin
        if (svc_start) begin
          next_seq = ief_pkg::SEQ_RST;
        end
        if (poll_in && (next_bursts < burst_lim)) begin
          // A start seen mid-burst still restarts numbering here
          if (fresh) begin
            next_seq = ief_pkg::SEQ_RST;
          end
          next_fresh  = 1'b0;
          next_bursts = next_bursts + 3'h1;
          next_left   = ief_clamp(poll_npkt_in, 5'h01, burst);
          next_st     = TX_HDR;
        end else if (poll_in) begin
          drop = 1'b1;
        end
      end
      TX_HDR: begin
        next_hdr.len  = len;
        next_hdr.seq  = seq;
        next_hdr.last = (len < pkt) || (left == 5'h01);
        next_seq      = seq + 5'h01;
        next_left     = left - 5'h01;
        next_bytes    = len;
        // Empty buffer still answers, never with a flow-control reply
        next_st = (len == 11'h000) ? TX_IDLE : TX_DATA;
      end
      TX_DATA: begin
        rd_ready   = 1'b1;
        next_bytes = bytes - 11'h001;
        if (bytes == 11'h001) begin
          next_st = hdr_out.last ? TX_IDLE : TX_HDR;
        end
      end
      default: begin
        next_st = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st       <= TX_IDLE;
      left     <= 5'h00;
      bursts   <= 3'h0;
      seq      <= ief_pkg::SEQ_RST;
      fresh    <= 1'b1;
      bytes    <= 11'h000;
      hdr_out  <= '0;
      hdr_valid_out  <= 1'b0;
      data_out       <= 8'h00;
      data_valid_out <= 1'b0;
      data_last_out  <= 1'b0;
      poll_drop_out  <= 1'b0;
    end else begin
      st       <= next_st;
      left     <= next_left;
      bursts   <= next_bursts;
      seq      <= next_seq;
      fresh    <= next_fresh;
      bytes    <= next_bytes;
      hdr_out  <= next_hdr;
      hdr_valid_out  <= (st == TX_HDR);
      data_out       <= rd_ready ? rd_data : data_out;
      data_valid_out <= rd_ready && rd_valid;
      data_last_out  <= rd_ready && (bytes == 11'h001);
      poll_drop_out  <= drop;
    end
  end
endmodule : ief_endpoint

/* verif/ief_endpoint_assertions.sv */
// Port checker of the isochronous endpoint.
// Assumes one clock domain; bound onto ief_endpoint.
`timescale 1ns/1ps
module ief_endpoint_assertions (
  input wire logic                 clk_in,
  input wire logic                 nrst_in,
  input wire ief_pkg::ief_cfg_type cfg_in,
  input wire logic                 bus_tick_in,
  input wire logic                 poll_in,
  input wire logic                 fb_poll_in,
  input wire ief_pkg::ief_hdr_type hdr_out,
  input wire logic                 hdr_valid_out,
  input wire logic                 data_valid_out,
  input wire logic                 data_last_out,
  input wire logic                 poll_drop_out,
  input wire logic [63:0]          fb_report_out,
  input wire logic                 fb_report_valid_out,
  input wire logic                 samples_valid_out
);
  // ----------
  // Helpers
  // ----------
  logic [10:0] left;
  logic [4:0]  last_seq;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      left     <= 11'h000;
      last_seq <= 5'h00;
    end else if (hdr_valid_out) begin
      left     <= hdr_out.len;
      last_seq <= hdr_out.seq;
    end else if (data_valid_out) begin
      left <= left - 11'h001;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_hdr_after_req:
    assert property (hdr_valid_out |-> $past(poll_in, 2) || $past(data_last_out))
      else $error("header without request");
  a_drop_late:
    assert property (poll_drop_out |-> $past(poll_in)) else $error("drop without poll");
  a_len_limit:
    assert property (hdr_valid_out |-> hdr_out.len <= 11'h400 &&
      (cfg_in.max_burst > 5'h01 || hdr_out.len <= cfg_in.max_pkt)) else $error("long packet");
  a_byte_count:
    assert property (data_last_out |-> data_valid_out && left == 11'h001) else $error("bytes");
  a_seq_step:
    assert property (hdr_valid_out && hdr_out.seq != 5'h00 |-> hdr_out.seq == last_seq + 5'h01)
      else $error("sequence gap");
  a_fb_answer:
    assert property (fb_poll_in |=> fb_report_valid_out) else $error("feedback missing");
  a_fb_format:
    assert property (fb_report_valid_out |-> fb_report_out[18:0] == 19'h0 &&
      fb_report_out[63:51] == 13'h0) else $error("feedback format");
  a_src_tick:
    assert property (samples_valid_out |-> $past(bus_tick_in)) else $error("samples off tick");
  c_zero_len: cover property (hdr_valid_out && hdr_out.len == 11'h000);
  c_drop: cover property (poll_drop_out);
  c_feedback: cover property (fb_report_valid_out);
endmodule : ief_endpoint_assertions

bind ief_endpoint ief_endpoint_assertions ief_endpoint_assertions_i (.clk_in(clk_in),
  .nrst_in(nrst_in), .cfg_in(cfg_in), .bus_tick_in(bus_tick_in), .poll_in(poll_in),
  .fb_poll_in(fb_poll_in), .hdr_out(hdr_out), .hdr_valid_out(hdr_valid_out),
  .data_valid_out(data_valid_out), .data_last_out(data_last_out),
  .poll_drop_out(poll_drop_out), .fb_report_out(fb_report_out),
  .fb_report_valid_out(fb_report_valid_out), .samples_valid_out(samples_valid_out));

/* verif/ief_host_model.sv */
// Host stand-in: bus interval markers and the adaptive source rate.
// Assumes reset shared with the endpoint; polls come from the bench.
`timescale 1ns/1ps
module ief_host_model #(
  parameter int          PERIOD = 128,
  parameter logic [63:0] RATE   = 64'h0000_0001_8000_0000
) (
  input  wire logic   clk_in,
  input  wire logic   nrst_in,
  output logic        bus_tick_out,
  output logic [63:0] host_rate_out,
  output logic        host_rate_valid_out
);
  int   cnt;
  logic sent;
  assign host_rate_out = RATE;
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      cnt <= 0;
      sent <= 1'b0;
      bus_tick_out <= 1'b0;
      host_rate_valid_out <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      bus_tick_out <= (cnt == PERIOD - 1);
      host_rate_valid_out <= !sent;
      sent <= 1'b1;
    end
  end
endmodule : ief_host_model

/* verif/ief_endpoint_tb_top.sv */
// Bench of the endpoint: host model, byte source, queue scoreboard.
// Assumes a 25 MHz clock; drift pulses nudge the reported rate.
`timescale 1ns/1ps
module ief_endpoint_tb_top;
  logic                 clk_in = 1'b0;
  logic                 nrst_in = 1'b0;
  ief_pkg::ief_cfg_type cfg = '{11'h004, 5'h01, 5'h01, 1'b0, 4'hC};
  logic                 poll = 1'b0, fb_poll = 1'b0, src_v = 1'b0, mclk = 1'b0;
  logic                 drift_up = 1'b0, drift_dn = 1'b0;
  logic [10:0]          rem = 11'h000;
  logic [4:0]           npkt = 5'h01;
  logic [7:0]           src_d = 8'h00;
  logic [15:0]          seed = 16'hBEE8;
  logic [31:0]          frac = 32'h0;
  logic [63:0]          sum, rate, fb;
  logic                 tick, rate_v, src_rdy, hdr_v, dat_v, dat_l, drop, fb_v, smp_v;
  logic [7:0]           dat;
  logic [15:0]          smp;
  ief_pkg::ief_hdr_type hdr;
  logic [63:0]          q_hdr[$], q_dat[$], q_smp[$], q_fb[$], q_drop[$];
  int                   failures = 0;
  int                   checks_done = 0;

  initial forever #20 clk_in = ~clk_in;
  always @(posedge clk_in) mclk <= ~mclk;

  ief_host_model ief_host_model_i (.clk_in(clk_in), .nrst_in(nrst_in), .bus_tick_out(tick),
    .host_rate_out(rate), .host_rate_valid_out(rate_v));
  ief_endpoint ief_endpoint_i (.clk_in(clk_in), .nrst_in(nrst_in), .cfg_in(cfg),
    .bus_tick_in(tick), .poll_in(poll), .poll_npkt_in(npkt), .fb_poll_in(fb_poll),
    .src_valid_in(src_v), .src_data_in(src_d), .src_ready_out(src_rdy), .hdr_out(hdr),
    .hdr_valid_out(hdr_v), .data_out(dat), .data_valid_out(dat_v), .data_last_out(dat_l),
    .poll_drop_out(drop), .mclk_pin_in(mclk), .drift_up_in(drift_up), .drift_dn_in(drift_dn),
    .fb_report_out(fb), .fb_report_valid_out(fb_v), .host_rate_in(rate),
    .host_rate_valid_in(rate_v), .samples_out(smp), .samples_valid_out(smp_v));

  // ----------
  // Tasks
  // ----------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic take(ref logic [63:0] q[$], input logic [63:0] seen);
    if (q.size() == 0) check(1'b0, 1'b1);
    else check(seen, q.pop_front());
  endtask : take
  task automatic tally_and_finish;
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic bail;
    failures++;
    tally_and_finish();
  endtask : bail
  task automatic wait_tick;
    int k;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (!tick && k < 300);
    if (!tick) bail();
  endtask : wait_tick
  // Holds valid until ready is seen high at an edge
  task automatic push_bytes(input int n);
    int k;
    repeat (n) begin
      seed = lfsr_next(seed);
      src_v <= 1'b1;
      src_d <= seed[7:0];
      q_dat.push_back({56'h0, seed[7:0]});
      k = 0;
      do begin
        @(posedge clk_in);
        k++;
      end while (!src_rdy && k < 50);
      if (!src_rdy) bail();
    end
    src_v <= 1'b0;
  endtask : push_bytes
  // Header two cycles after the poll, then one byte per cycle
  task automatic poll_req(input logic [4:0] n, input logic [10:0] len, input logic [4:0] sq,
                          input logic dropped);
    if (dropped) q_drop.push_back(64'h1);
    // Every packet here is short or alone in a one-packet burst, so each one ends its burst
    else q_hdr.push_back({47'h0, 1'b1, len, sq});
    poll <= 1'b1;
    npkt <= n;
    @(posedge clk_in);
    poll <= 1'b0;
    repeat (len + 11'h004) @(posedge clk_in);
  endtask : poll_req

  // ----------
  // Scoreboard and sequence
  // ----------
  always @(posedge clk_in) begin
    if (tick) begin
      sum = {32'h0, frac} + rate;
      q_smp.push_back({48'h0, sum[47:32]});
      frac = sum[31:0];
    end
    if (hdr_v) begin
      rem = (q_hdr.size() > 0) ? q_hdr[0][15:5] : 11'h000;
      take(q_hdr, {47'h0, hdr.last, hdr.len, hdr.seq});
    end
    if (dat_v) begin
      take(q_dat, {56'h0, dat});
      rem = rem - 11'h001;
      check(dat_l, rem == 11'h000);
    end else if (dat_l) check(dat_l, 1'b0);
    if (smp_v) take(q_smp, {48'h0, smp});
    if (fb_v) take(q_fb, fb);
    if (drop) take(q_drop, 64'h1);
  end

  initial begin
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    wait_tick();
    poll_req(5'h01, 11'h000, 5'h00, 1'b0);
    push_bytes(6);
    poll_req(5'h01, 11'h004, 5'h01, 1'b0);
    poll_req(5'h01, 11'h002, 5'h02, 1'b0);
    poll_req(5'h01, 11'h000, 5'h00, 1'b1);
    wait_tick();
    push_bytes(3);
    poll_req(5'h01, 11'h003, 5'h00, 1'b0);
    cfg <= '{11'h004, 5'h14, 5'h01, 1'b1, 4'hC};
    push_bytes(32);
    @(posedge clk_in);
    check(src_rdy, 1'b0);
    wait_tick();
    poll_req(5'h03, 11'h020, 5'h00, 1'b0);
    check(src_rdy, 1'b1);
    repeat (4) wait_tick();
    q_fb.push_back(64'h0000_0000_0400_0000);
    q_fb.push_back(64'h0000_0000_0400_0000);
    fb_poll <= 1'b1;
    repeat (2) @(posedge clk_in);
    fb_poll <= 1'b0;
    // One drift pulse moves the next loaded count by one step each way
    for (int i = 0; i < 2; i++) begin
      drift_up <= (i == 0);
      drift_dn <= (i == 1);
      @(posedge clk_in);
      drift_up <= 1'b0;
      drift_dn <= 1'b0;
      repeat (2) wait_tick();
      q_fb.push_back((i == 0) ? 64'h0000_0000_0408_0000 : 64'h0000_0000_03F8_0000);
      fb_poll <= 1'b1;
      @(posedge clk_in);
      fb_poll <= 1'b0;
    end
    repeat (3) @(posedge clk_in);
    check(q_hdr.size() + q_dat.size() + q_fb.size() + q_drop.size(), 0);
    tally_and_finish();
  end
endmodule : ief_endpoint_tb_top
